// >>> design/ats_defines.vh
`ifndef ATS_DEFINES_VH
`define ATS_DEFINES_VH

// ----------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------
`define ATS_A_CTRL        4'h0
`define ATS_A_CMD         4'h1
`define ATS_A_FRAMES      4'h2
`define ATS_A_BURST       4'h3
`define ATS_A_PERIOD      4'h4
`define ATS_A_SHUTTER     4'h5
`define ATS_A_DELAY       4'h6
`define ATS_A_READOUT     4'h7
`define ATS_A_STATUS      4'h8
`define ATS_A_ACHIEVED    4'h9
`define ATS_A_AUTO_SHUT   4'hA

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ATS_C_STYLE_LO    0
`define ATS_C_STYLE_HI    1
`define ATS_C_MANUAL      2
`define ATS_C_PULSE       3
`define ATS_C_AUTO_LO     4
`define ATS_C_AUTO_HI     5
`define ATS_C_GATE        6
`define ATS_C_KIND_LO     7
`define ATS_C_KIND_HI     8
`define ATS_C_ORIG_LO     9
`define ATS_C_ORIG_HI     11
`define ATS_C_SENSE_LO    12
`define ATS_C_SENSE_HI    14
`define ATS_C_OVERLAP     15
`define ATS_CTRL_W        16
// continuous style, auto off manual, fixed shutter, auto continuous, gate off
`define ATS_CTRL_RST      16'h0020

// command bits
`define ATS_CMD_BEGIN     0
`define ATS_CMD_HALT      1
`define ATS_CMD_SWTRIG    2

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define ATS_RUN_CONT      2'h0
`define ATS_RUN_ONE       2'h1
`define ATS_RUN_COUNTED   2'h2

`define ATS_AUTO_OFF      2'h0
`define ATS_AUTO_ONCE     2'h1
`define ATS_AUTO_CONT     2'h2

`define ATS_KIND_ACQ      2'h0
`define ATS_KIND_FRAME    2'h1
`define ATS_KIND_BURST    2'h2

`define ATS_ORIG_LINE     3'h0
`define ATS_ORIG_USER     3'h1
`define ATS_ORIG_CNT      3'h2
`define ATS_ORIG_LOGIC    3'h3
`define ATS_ORIG_SW       3'h4

`define ATS_SENSE_LOW     3'h0
`define ATS_SENSE_HIGH    3'h1
`define ATS_SENSE_FALL    3'h2
`define ATS_SENSE_RISE    3'h3
`define ATS_SENSE_ANY     3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ATS_CLK_MHZ       25
// last prescaler count of one microsecond at 25 MHz
`define ATS_US_LAST       5'h18
`define ATS_AUTO_ONCE_FRAMES 16'h0004
`define ATS_DEF_PERIOD    32'h0000FFFF
`define ATS_DEF_SHUTTER   32'h000003E8
`define ATS_DEF_READOUT   32'h00000100

`endif

// >>> design/ats_sequencer.v
//
// Contract
// [R1] three run styles; continuous after reset
// [R2] one-shot captures one frame then ends
// [R3] counted captures multi_capture_total then ends
// [R4] begin command starts, halt command stops
// [R5] manual rate switch paces; off after reset
// [R6] report achieved rate, slower when exposure longer
// [R7] fixed or pulse-length shutter, fixed default
// [R8] fixed manual shutter lasts shutter_duration_us
// [R9] auto once adapts briefly then returns off; auto_shut_q keeps its reset value
// [R10] auto continuous adapts forever; reset default; auto_shut_q keeps its reset value
// [R11] triggers ignored while gate switch off
// [R12] acquisition-start trigger runs the run style
// [R13] frame-start one-shot/counted needs new begin
// [R14] frame-start continuous: one frame per trigger
// [R15] burst overridden by one-shot and counted
// [R16] burst continuous: burst total per trigger
// [R17] trigger origin select picks the source
// [R18] trigger sense: levels, edges, either edge
// [R19] readout overlap policy drops or accepts
// [R20] delay trigger_to_shutter_delay before exposure
// [R21] software trigger command when origin software
// [R22] pulse shutter open while trigger stays active
// [R23] halt cancels pending frames, back to idle
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ats_defines.vh"
module ats_sequencer #(
  parameter CW = 32
) (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire [3:0]  trig_line_i,
  input  wire [3:0]  trig_user_i,
  input  wire [3:0]  trig_cnt_i,
  input  wire [3:0]  trig_logic_i,
  input  wire [1:0]  trig_index_i,
  output reg         exposing_o,
  output reg         reading_o,
  output reg         frame_done_o,
  output reg         acquiring_o
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'h0;
  localparam ST_ARMED = 3'h1;
  localparam ST_DELAY = 3'h2;
  localparam ST_EXPO  = 3'h3;
  localparam ST_READ  = 3'h4;
  localparam ST_GAP   = 3'h5;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [`ATS_CTRL_W-1:0] ctrl_q;
  reg [CW-1:0]          frames_q;
  reg [CW-1:0]          burst_q;
  reg [CW-1:0]          period_q;
  reg [CW-1:0]          shutter_q;
  reg [CW-1:0]          delay_q;
  reg [CW-1:0]          readout_q;
  reg [CW-1:0]          auto_shut_q;
  reg [CW-1:0]          achieved_q;
  reg [2:0]             state_q;
  reg [CW-1:0]          timer_q;
  reg [CW-1:0]          us_left_q;
  reg [CW-1:0]          left_q;
  reg [CW-1:0]          frame_age_q;
  reg [15:0]            once_q;
  reg                   sw_trig_q;
  reg                   overlap_q;
  reg [4:0]             us_div_q;

  wire [1:0] run_style = ctrl_q[`ATS_C_STYLE_HI:`ATS_C_STYLE_LO];
  wire [1:0] auto_mode = ctrl_q[`ATS_C_AUTO_HI:`ATS_C_AUTO_LO];
  wire [1:0] kind      = ctrl_q[`ATS_C_KIND_HI:`ATS_C_KIND_LO];
  wire [2:0] origin    = ctrl_q[`ATS_C_ORIG_HI:`ATS_C_ORIG_LO];
  wire [2:0] sense     = ctrl_q[`ATS_C_SENSE_HI:`ATS_C_SENSE_LO];
  wire       gate_on   = ctrl_q[`ATS_C_GATE];
  wire       pulse_mode = ctrl_q[`ATS_C_PULSE];
  wire       manual    = ctrl_q[`ATS_C_MANUAL];

  wire wr_cmd = reg_wr && (reg_addr == `ATS_A_CMD);
  wire cmd_begin = wr_cmd && reg_wdata[`ATS_CMD_BEGIN];
  wire cmd_halt  = wr_cmd && reg_wdata[`ATS_CMD_HALT];
  wire cmd_sw    = wr_cmd && reg_wdata[`ATS_CMD_SWTRIG];

  // ----------------------------------------------------------------
  // trigger path
  // ----------------------------------------------------------------
  wire [15:0] pins_s;
  ats_sync2 #(.W(16)) u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .async_i ({trig_logic_i, trig_cnt_i, trig_user_i, trig_line_i}),
    .sync_o  (pins_s)
  );

  reg trig_level;
  always @* begin
    case (origin) // see [R17]
      `ATS_ORIG_LINE:  trig_level = pins_s[{2'h0, trig_index_i}];
      `ATS_ORIG_USER:  trig_level = pins_s[{2'h1, trig_index_i}];
      `ATS_ORIG_CNT:   trig_level = pins_s[{2'h2, trig_index_i}];
      `ATS_ORIG_LOGIC: trig_level = pins_s[{2'h3, trig_index_i}];
      `ATS_ORIG_SW:    trig_level = sw_trig_q; // see [R21]
      default:         trig_level = 1'b0;
    endcase
  end

  wire trig_hit;
  wire trig_active;
  ats_trig_detect u_det (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .level_i  (trig_level),
    .sense_i  (sense),
    .hit_o    (trig_hit),
    .active_o (trig_active)
  );
  wire trig = gate_on && trig_hit; // see [R11]

  // ----------------------------------------------------------------
  // microsecond tick
  // ----------------------------------------------------------------
  // the prescaler restarts with every timed phase, so a count of n lasts
  // n whole microseconds rather than anywhere between n-1 and n
  wire us_tick = (us_div_q == `ATS_US_LAST);

  // frames to take on an acquisition or burst start
  reg [CW-1:0] batch;
  always @* begin
    case (run_style) // see [R15]
      `ATS_RUN_ONE:     batch = {{(CW-1){1'b0}}, 1'b1}; // see [R2]
      `ATS_RUN_COUNTED: batch = frames_q; // see [R3]
      default: begin
        if (gate_on && kind == `ATS_KIND_BURST)
          batch = burst_q; // see [R16]
        else if (gate_on && kind == `ATS_KIND_FRAME)
          batch = {{(CW-1){1'b0}}, 1'b1}; // see [R14]
        else
          batch = {CW{1'b0}}; // zero means endless; see [R1]
      end
    endcase
  end

  // auto shutter: once uses auto_shut_q a few frames, continuous forever; see [R9] [R10]
  wire [CW-1:0] exp_us = (auto_mode == `ATS_AUTO_OFF) ? shutter_q : auto_shut_q; // see [R8]
  // manual period paces; automatic runs back to back
  wire [CW-1:0] gap_cyc = manual ? period_q : {CW{1'b0}}; // see [R5]
  wire          per_trigger = gate_on && (kind != `ATS_KIND_ACQ);
  wire          more = (left_q != {{(CW-1){1'b0}}, 1'b1});
  wire          endless = (left_q == {CW{1'b0}});

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q      <= ST_IDLE;
      timer_q      <= {CW{1'b0}};
      us_left_q    <= {CW{1'b0}};
      left_q       <= {CW{1'b0}};
      us_div_q     <= 5'h00;
      exposing_o   <= 1'b0;
      reading_o    <= 1'b0;
      frame_done_o <= 1'b0;
      acquiring_o  <= 1'b0;
      overlap_q    <= 1'b0;
      frame_age_q  <= {CW{1'b0}};
      achieved_q   <= {CW{1'b0}};
      once_q       <= 16'h0000;
      auto_shut_q  <= `ATS_DEF_SHUTTER;
    end else begin
      frame_done_o <= 1'b0;
      us_div_q <= us_tick ? 5'h00 : us_div_q + 5'h01;
      frame_age_q <= frame_age_q + {{(CW-1){1'b0}}, 1'b1};
      if (cmd_halt) begin // see [R4] [R23]
        state_q     <= ST_IDLE;
        exposing_o  <= 1'b0;
        reading_o   <= 1'b0;
        acquiring_o <= 1'b0;
        overlap_q   <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: if (cmd_begin) begin // see [R4]
            acquiring_o <= 1'b1;
            left_q      <= batch;
            if (gate_on) begin
              state_q <= ST_ARMED; // see [R12] [R13]
            end else begin
              state_q   <= ST_EXPO;
              exposing_o <= 1'b1;
              us_left_q <= exp_us;
              us_div_q  <= 5'h00;
            end
          end
          ST_ARMED: if (trig) begin
            left_q    <= batch;
            state_q   <= ST_DELAY;
            us_left_q <= delay_q; // see [R20]
            us_div_q  <= 5'h00;
          end
          ST_DELAY: begin
            if (us_left_q == {CW{1'b0}}) begin
              us_div_q   <= 5'h00;
              state_q    <= ST_EXPO;
              exposing_o <= 1'b1;
              us_left_q  <= exp_us;
            end else if (us_tick) begin
              us_left_q <= us_left_q - {{(CW-1){1'b0}}, 1'b1};
            end
          end
          ST_EXPO: begin
            if (pulse_mode ? !trig_active
                           : (us_left_q == {CW{1'b0}})) begin // see [R7] [R22]
              exposing_o <= 1'b0;
              reading_o  <= 1'b1;
              timer_q    <= readout_q;
              overlap_q  <= 1'b0;
              state_q    <= ST_READ;
            end else if (us_tick && !pulse_mode) begin
              us_left_q <= us_left_q - {{(CW-1){1'b0}}, 1'b1};
            end
          end
          ST_READ: begin
            // with overlap accepted, a trigger in the readout of a batch's last frame is kept for the next batch
            if (trig && ctrl_q[`ATS_C_OVERLAP] && per_trigger) overlap_q <= 1'b1; // see [R19]
            if (timer_q == {CW{1'b0}}) begin
              reading_o    <= 1'b0;
              frame_done_o <= 1'b1;
              // achieved rate given as cycles between frame ends; see [R6]
              achieved_q   <= frame_age_q;
              frame_age_q  <= {CW{1'b0}};
              if (auto_mode == `ATS_AUTO_ONCE && once_q != 16'hFFFF)
                once_q <= once_q + 16'h0001;
              timer_q <= gap_cyc;
              state_q <= ST_GAP;
            end else begin
              timer_q <= timer_q - {{(CW-1){1'b0}}, 1'b1};
            end
          end
          ST_GAP: begin
            if (timer_q != {CW{1'b0}}) begin
              timer_q <= timer_q - {{(CW-1){1'b0}}, 1'b1};
            end else if (endless || more) begin
              if (!endless) left_q <= left_q - {{(CW-1){1'b0}}, 1'b1};
              us_div_q   <= 5'h00;
              state_q    <= ST_EXPO;
              exposing_o <= 1'b1;
              us_left_q  <= exp_us;
            end else if (per_trigger && run_style == `ATS_RUN_CONT) begin
              if (overlap_q) begin
                overlap_q <= 1'b0;
                left_q    <= batch;
                state_q   <= ST_DELAY;
                us_left_q <= delay_q;
                us_div_q  <= 5'h00;
              end else begin
                state_q <= ST_ARMED; // see [R14] [R16]
              end
            end else begin
              acquiring_o <= 1'b0; // see [R2] [R3] [R13]
              state_q     <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
      if (auto_mode == `ATS_AUTO_OFF) once_q <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // a host write in the same cycle wins; the revert then follows a cycle later
  wire once_done = (auto_mode == `ATS_AUTO_ONCE) && (once_q >= `ATS_AUTO_ONCE_FRAMES);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q    <= `ATS_CTRL_RST; // see [R1] [R5] [R7] [R10] [R11]
      frames_q  <= {{(CW-1){1'b0}}, 1'b1};
      burst_q   <= {{(CW-1){1'b0}}, 1'b1};
      period_q  <= `ATS_DEF_PERIOD;
      shutter_q <= `ATS_DEF_SHUTTER;
      delay_q   <= {CW{1'b0}};
      readout_q <= `ATS_DEF_READOUT;
      sw_trig_q <= 1'b0;
    end else begin
      sw_trig_q <= cmd_sw && (origin == `ATS_ORIG_SW); // see [R21]
      if (reg_wr) begin
        case (reg_addr)
          `ATS_A_CTRL:    ctrl_q    <= reg_wdata[`ATS_CTRL_W-1:0];
          `ATS_A_FRAMES:  frames_q  <= reg_wdata[CW-1:0];
          `ATS_A_BURST:   burst_q   <= reg_wdata[CW-1:0];
          `ATS_A_PERIOD:  period_q  <= reg_wdata[CW-1:0];
          `ATS_A_SHUTTER: shutter_q <= reg_wdata[CW-1:0];
          `ATS_A_DELAY:   delay_q   <= reg_wdata[CW-1:0];
          `ATS_A_READOUT: readout_q <= reg_wdata[CW-1:0];
          default: ;
        endcase
      end else if (once_done) begin
        ctrl_q[`ATS_C_AUTO_HI:`ATS_C_AUTO_LO] <= `ATS_AUTO_OFF; // see [R9]
        shutter_q <= auto_shut_q;
      end
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ATS_A_CTRL:      reg_rdata <= {{(32-`ATS_CTRL_W){1'b0}}, ctrl_q};
        `ATS_A_FRAMES:    reg_rdata <= frames_q;
        `ATS_A_BURST:     reg_rdata <= burst_q;
        `ATS_A_PERIOD:    reg_rdata <= period_q;
        `ATS_A_SHUTTER:   reg_rdata <= shutter_q;
        `ATS_A_DELAY:     reg_rdata <= delay_q;
        `ATS_A_READOUT:   reg_rdata <= readout_q;
        `ATS_A_STATUS:    reg_rdata <= {26'h0000000, acquiring_o, reading_o,
                                        exposing_o, state_q};
        `ATS_A_ACHIEVED:  reg_rdata <= achieved_q; // see [R6]
        `ATS_A_AUTO_SHUT: reg_rdata <= auto_shut_q;
        default:          reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// >>> design/ats_sync2.v
`timescale 1ns/1ps
`default_nettype none
module ats_sync2 #(
  parameter W = 4
) (
  input  wire         clk_sys,
  input  wire         arst_n,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule
`default_nettype wire

// >>> design/ats_trig_detect.v
`timescale 1ns/1ps
`default_nettype none
`include "ats_defines.vh"
module ats_trig_detect (
  input  wire       clk_sys,
  input  wire       arst_n,
  input  wire       level_i,
  input  wire [2:0] sense_i,
  output reg        hit_o,
  output reg        active_o
);
  reg prev_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_i;
    end
  end
  // level senses fire every cycle they hold; the sequencer only samples when ready
  always @* begin
    hit_o    = 1'b0;
    active_o = level_i;
    case (sense_i) // see [R18]
      `ATS_SENSE_LOW: begin
        hit_o    = !level_i;
        active_o = !level_i;
      end
      `ATS_SENSE_HIGH: hit_o = level_i;
      `ATS_SENSE_FALL: begin
        hit_o    = prev_q && !level_i;
        active_o = !level_i;
      end
      `ATS_SENSE_RISE: hit_o = !prev_q && level_i;
      `ATS_SENSE_ANY:  hit_o = prev_q ^ level_i;
      default:         hit_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// >>> testbench/acquisition_trigger_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ats_defines.vh"
module acquisition_trigger_sequencer_tb_top;
  logic        clk_sys;
  logic        arst_n;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [1:0]  trig_index_i;
  logic [31:0] rv;
  wire  [31:0] reg_rdata;
  wire  [15:0] trig_w;
  wire         exposing_o, reading_o, frame_done_o, acquiring_o;
  int          err_count, total_checks, nf, n;

  ats_trig_model src (.clk_sys(clk_sys), .pins_o(trig_w));
  ats_sequencer #(.CW(32)) dut (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .trig_line_i  (trig_w[3:0]),
    .trig_user_i  (trig_w[7:4]),
    .trig_cnt_i   (trig_w[11:8]),
    .trig_logic_i (trig_w[15:12]),
    .trig_index_i (trig_index_i),
    .exposing_o   (exposing_o),
    .reading_o    (reading_o),
    .frame_done_o (frame_done_o),
    .acquiring_o  (acquiring_o)
  );
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic watch(input int c);
    repeat (c) begin
      @(posedge clk_sys);
      #1;
      if (frame_done_o === 1'b1) nf++;
    end
  endtask
  // manual pacing, auto shutter off, fixed shutter, rising sense, no overlap
  function automatic logic [31:0] mk(input logic [1:0] st, input logic [1:0] kd,
                                     input logic [2:0] og, input logic g);
    return {16'h0000, 1'b0, `ATS_SENSE_RISE, og, kd, g, `ATS_AUTO_OFF, 1'b0, 1'b1, st};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(`ATS_A_CTRL);
    chk("ctrl reset", `ATS_CTRL_RST, rv);
    rd(4'hF);
    chk("unmapped read", 32'h0, rv);
  endtask
  task automatic t_one;
    wr(`ATS_A_CTRL, mk(`ATS_RUN_ONE, `ATS_KIND_ACQ, `ATS_ORIG_LINE, 1'b0));
    nf = 0;
    wr(`ATS_A_CMD, 32'h1);
    watch(400);
    chk("one-shot frames", 32'h1, nf);
    chk("one-shot ends", 32'h0, acquiring_o);
  endtask
  task automatic t_counted;
    wr(`ATS_A_FRAMES, 32'h3);
    wr(`ATS_A_CTRL, mk(`ATS_RUN_COUNTED, `ATS_KIND_ACQ, `ATS_ORIG_LINE, 1'b0));
    nf = 0;
    wr(`ATS_A_CMD, 32'h1);
    watch(900);
    chk("counted frames", 32'h3, nf);
    chk("counted ends", 32'h0, acquiring_o);
    rd(`ATS_A_ACHIEVED);
    chk("achieved slower", 32'h1, rv > 32'h32);
  endtask
  task automatic t_cont_halt;
    wr(`ATS_A_CTRL, mk(`ATS_RUN_CONT, `ATS_KIND_ACQ, `ATS_ORIG_LINE, 1'b0));
    nf = 0;
    wr(`ATS_A_CMD, 32'h1);
    watch(400);
    chk("continuous runs", 32'h1, nf >= 2);
    wr(`ATS_A_CMD, 32'h2);
    watch(4);
    chk("halt idle", 32'h0, acquiring_o);
    nf = 0;
    watch(300);
    chk("frames after halt", 32'h0, nf);
  endtask
  task automatic t_gate;
    wr(`ATS_A_CTRL, mk(`ATS_RUN_CONT, `ATS_KIND_FRAME, `ATS_ORIG_LINE, 1'b1));
    nf = 0;
    wr(`ATS_A_CMD, 32'h1);
    watch(200);
    chk("armed no trigger", 32'h0, nf);
    // gate dropped while armed: the trigger must not start a frame
    wr(`ATS_A_CTRL, mk(`ATS_RUN_CONT, `ATS_KIND_FRAME, `ATS_ORIG_LINE, 1'b0));
    src.fire(1, 4);
    watch(200);
    chk("gate off frames", 32'h0, nf);
    wr(`ATS_A_CTRL, mk(`ATS_RUN_CONT, `ATS_KIND_FRAME, `ATS_ORIG_LINE, 1'b1));
    src.fire(5, 4);
    watch(200);
    chk("other source", 32'h0, nf);
    repeat (3) begin
      src.fire(1, 4);
      watch(250);
    end
    chk("frame per trigger", 32'h3, nf);
    // low-level sense with the pin idle low re-arms at once, frame after frame
    wr(`ATS_A_CTRL, mk(`ATS_RUN_CONT, `ATS_KIND_FRAME, `ATS_ORIG_LINE, 1'b1) & 32'hFFFF8FFF);
    watch(250);
    chk("low level repeats", 32'h1, nf >= 5);
    wr(`ATS_A_CMD, 32'h2);
  endtask
  task automatic t_frame_one;
    wr(`ATS_A_CTRL, mk(`ATS_RUN_ONE, `ATS_KIND_FRAME, `ATS_ORIG_LINE, 1'b1));
    nf = 0;
    wr(`ATS_A_CMD, 32'h1);
    src.fire(1, 4);
    watch(250);
    chk("frame-start one-shot", 32'h1, nf);
    src.fire(1, 4);
    watch(250);
    chk("no frame before begin", 32'h1, nf);
    wr(`ATS_A_CMD, 32'h1);
    src.fire(1, 4);
    watch(250);
    chk("frame after begin", 32'h2, nf);
  endtask
  task automatic t_burst;
    wr(`ATS_A_BURST, 32'h2);
    wr(`ATS_A_DELAY, 32'h1);
    wr(`ATS_A_CTRL, mk(`ATS_RUN_CONT, `ATS_KIND_BURST, `ATS_ORIG_SW, 1'b1));
    nf = 0;
    wr(`ATS_A_CMD, 32'h1);
    watch(100);
    chk("burst idle", 32'h0, nf);
    for (int k = 1; k <= 2; k++) begin
      wr(`ATS_A_CMD, 32'h4);
      n = 0;
      while (exposing_o !== 1'b1) begin
        @(posedge clk_sys);
        #1;
        n++;
        if (n > 300) begin
          err_count++;
          final_report;
        end
      end
      chk("trigger delay", 32'h1, n >= 25 && n <= 45);
      watch(500);
      chk("burst frames", 2 * k, nf);
    end
    wr(`ATS_A_CMD, 32'h2);
  endtask

  initial begin
    arst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    trig_index_i = 2'h1;
    err_count = 0;
    total_checks = 0;
    nf = 0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset;
    wr(`ATS_A_SHUTTER, 32'h2);
    wr(`ATS_A_READOUT, 32'h4);
    wr(`ATS_A_PERIOD, 32'hA);
    wr(`ATS_A_DELAY, 32'h0);
    t_one;
    t_counted;
    t_cont_halt;
    t_gate;
    t_frame_one;
    t_burst;
    final_report;
  end
endmodule
`default_nettype wire

// >>> testbench/ats_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "ats_defines.vh"
module ats_seq_chk #(
  parameter int CW = 32
) (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0]  trig_line_i,
  input wire logic [3:0]  trig_user_i,
  input wire logic [3:0]  trig_cnt_i,
  input wire logic [3:0]  trig_logic_i,
  input wire logic [1:0]  trig_index_i,
  input wire logic        exposing_o,
  input wire logic        reading_o,
  input wire logic        frame_done_o,
  input wire logic        acquiring_o
);
  // ----------------------------------------------------------------
  // shadow of host settings
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [31:0] shut_q;
  logic [31:0] exp_cnt_q;
  wire         cmd_w   = reg_wr && reg_addr == `ATS_A_CMD;
  wire         begin_w = cmd_w && reg_wdata[`ATS_CMD_BEGIN];
  wire         halt_w  = cmd_w && reg_wdata[`ATS_CMD_HALT];
  wire         fixed_w = ctrl_q[5:4] == `ATS_AUTO_OFF && !ctrl_q[`ATS_C_PULSE];
  wire  [31:0] exp_n_w = shut_q * `ATS_CLK_MHZ;

  // auto once rewrites the auto bits inside, so readback is not compared then
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q    <= `ATS_CTRL_RST;
      shut_q    <= `ATS_DEF_SHUTTER;
      exp_cnt_q <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == `ATS_A_CTRL) ctrl_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `ATS_A_SHUTTER) shut_q <= reg_wdata;
      exp_cnt_q <= (frame_done_o || !acquiring_o) ? 32'h0 : exp_cnt_q + exposing_o;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_ctrl_rb;
    reg_rd && reg_addr == `ATS_A_CTRL && ctrl_q[5:4] != `ATS_AUTO_ONCE
      |=> reg_rdata[15:0] == ctrl_q;
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  property p_exp_in_acq;
    exposing_o |-> acquiring_o;
  endproperty
  a_exp_in_acq: assert property (p_exp_in_acq) else $error("exposure while idle");
  property p_halt_stop;
    halt_w |-> ##[1:3] (!acquiring_o && !exposing_o);
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halt did not stop");
  property p_halt_quiet;
    halt_w |-> ##3 (!frame_done_o) [*8];
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("frame after halt");
  property p_gate_off;
    $rose(acquiring_o) && !ctrl_q[`ATS_C_GATE] |-> $past(begin_w) || $past(begin_w, 2);
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("start without command");
  property p_exp_len;
    frame_done_o && fixed_w |-> exp_cnt_q inside {[exp_n_w - 1 : exp_n_w + 1]};
  endproperty
  a_exp_len: assert property (p_exp_len) else $error("exposure length wrong");
  property p_done_read;
    frame_done_o |-> $past(reading_o) || $past(reading_o, 2);
  endproperty
  a_done_read: assert property (p_done_read) else $error("done without readout");
  property p_done_pulse;
    frame_done_o |=> !frame_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one");

  c_frame: cover property (frame_done_o);
  c_gated: cover property ($rose(acquiring_o) && ctrl_q[`ATS_C_GATE]);
  c_halt: cover property (halt_w && acquiring_o);
endmodule

bind ats_sequencer ats_seq_chk #(.CW(CW)) u_chk (
  .clk_sys      (clk_sys),
  .arst_n       (arst_n),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_rdata    (reg_rdata),
  .trig_line_i  (trig_line_i),
  .trig_user_i  (trig_user_i),
  .trig_cnt_i   (trig_cnt_i),
  .trig_logic_i (trig_logic_i),
  .trig_index_i (trig_index_i),
  .exposing_o   (exposing_o),
  .reading_o    (reading_o),
  .frame_done_o (frame_done_o),
  .acquiring_o  (acquiring_o)
);
`default_nettype wire

// >>> testbench/ats_trig_model.sv
`timescale 1ns/1ps
`default_nettype none
module ats_trig_model (
  input  wire logic        clk_sys,
  output var  logic [15:0] pins_o
);
  // four groups of four: lines, user outputs, counters, logic blocks; idle low
  initial pins_o = 16'h0000;
  task automatic fire(input int b, input int len);
    @(posedge clk_sys);
    pins_o[b] <= 1'b1;
    repeat (len) @(posedge clk_sys);
    pins_o[b] <= 1'b0;
  endtask
endmodule
`default_nettype wire
